// ### rtl/fspc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "fspc_map.svh"
// self-programming sequencer; cpu drives ops, flash array sits outside
module fspc_ctrl #(
    parameter int PAGE_W = 7,
    parameter int WORD_W = 5,
    parameter int PROG_CYCLES = `FSPC_PROG_CYC,
    parameter int STALL_FIRST_PAGE = 112,
    parameter logic [7:0] SIG0 = 8'h5a, // arbitrary value
    parameter logic [7:0] SIG1 = 8'h3c, // arbitrary value
    parameter logic [7:0] SIG2 = 8'h42, // arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80 // arbitrary value
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic store_program_op,
    input wire logic load_program_op,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] r1r0,
    input wire logic eeprom_write_busy,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [7:0] ext_fuse_byte,
    input wire logic chip_erase,
    output logic lpm_special,
    output logic [7:0] lpm_data,
    output logic cpu_stall,
    output logic rww_read_block,
    output logic flash_erase,
    output logic flash_write,
    output logic [PAGE_W-1:0] flash_page,
    input wire logic [WORD_W-1:0] flash_word,
    output logic [15:0] flash_wdata,
    output logic [5:0] lock_bits,
    output logic spm_irq
);
    fspc_pkg::fspc_state_e state_reg;
    fspc_pkg::fspc_op_e op_reg;
    logic [5:0] arm_reg;
    logic [2:0] win_reg;
    logic rww_busy_reg;
    logic ie_reg;
    logic [31:0] cnt_reg;
    logic [5:0] lock_reg;
    logic load_active_reg;
    logic buf_clear;
    logic buf_wr;
    logic [(1<<WORD_W)-1:0] buf_valid;
    logic csr_wr;
    logic [31:0] prog_len_reg;
    logic store_hit;
    logic load_hit;
    logic done;
    logic [PAGE_W-1:0] page_field;

    // page_field sits above word_field in the byte pointer
    assign page_field = z_ptr[WORD_W+1 +: PAGE_W];
    assign csr_wr = reg_wr && (reg_addr == `FSPC_CSR_ADDR);
    assign store_hit = (state_reg == fspc_pkg::FSPC_ARMED) && store_program_op
                       && !eeprom_write_busy;
    assign load_hit = (state_reg == fspc_pkg::FSPC_ARMED) && load_program_op
                      && (win_reg < `FSPC_LD_WIN) && !eeprom_write_busy;
    assign done = (state_reg == fspc_pkg::FSPC_PROG) && (cnt_reg == 32'h0000_0000);

    // arming code decode, shared by several consumers
    function automatic logic is_cmd(input logic [5:0] a, input logic [5:0] c);
        is_cmd = (a == c);
    endfunction : is_cmd

    // arming register and window; store window 4, load window 3
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= fspc_pkg::FSPC_IDLE;
            arm_reg <= 6'h00;
            win_reg <= 3'h0;
            op_reg <= fspc_pkg::FSPC_OP_NONE;
        end else begin
            unique case (state_reg)
                fspc_pkg::FSPC_IDLE: begin
                    if (csr_wr && reg_wdata[`FSPC_B_ENABLE] && !eeprom_write_busy) begin
                        state_reg <= fspc_pkg::FSPC_ARMED;
                        arm_reg <= reg_wdata[5:0];
                        win_reg <= 3'h0;
                    end
                end
                fspc_pkg::FSPC_ARMED: begin
                    win_reg <= win_reg + 3'h1;
                    if (store_hit && arm_reg == `FSPC_CMD_ERASE) begin
                        state_reg <= fspc_pkg::FSPC_PROG;
                        op_reg <= fspc_pkg::FSPC_OP_ERASE;
                    end else if (store_hit && arm_reg == `FSPC_CMD_WRITE) begin
                        state_reg <= fspc_pkg::FSPC_PROG;
                        op_reg <= fspc_pkg::FSPC_OP_WRITE;
                    end else if (store_hit && arm_reg == `FSPC_CMD_LOCK) begin
                        state_reg <= fspc_pkg::FSPC_PROG;
                        op_reg <= fspc_pkg::FSPC_OP_LOCK;
                    end else if (store_hit || load_hit
                                 || win_reg == `FSPC_ST_WIN - 3'h1) begin
                        state_reg <= fspc_pkg::FSPC_IDLE;
                        arm_reg <= 6'h00;
                    end
                end
                fspc_pkg::FSPC_PROG: begin
                    if (done) begin
                        state_reg <= fspc_pkg::FSPC_IDLE;
                        arm_reg <= 6'h00;
                        op_reg <= fspc_pkg::FSPC_OP_NONE;
                    end
                end
                default: begin
                    state_reg <= fspc_pkg::FSPC_IDLE;
                end
            endcase
        end
    end

    // programming timer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_reg == fspc_pkg::FSPC_ARMED && store_hit) begin
            cnt_reg <= 32'(PROG_CYCLES - 1);
        end else if (cnt_reg != 32'h0000_0000) begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
        end
    end

    // cycles spent in the current program operation, watched by a_prog_time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_len_reg <= 32'h0000_0000;
        end else if (state_reg == fspc_pkg::FSPC_PROG) begin
            prog_len_reg <= prog_len_reg + 32'h0000_0001;
        end else begin
            prog_len_reg <= 32'h0000_0000;
        end
    end

    // latched page for erase and write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_page <= '0;
        end else if (store_hit && (arm_reg == `FSPC_CMD_ERASE || arm_reg == `FSPC_CMD_WRITE)) begin
            flash_page <= page_field;
        end
    end

    // busy flag set as erase or write starts, cleared by re-enable command
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rww_busy_reg <= 1'b0;
        end else if (store_hit && (is_cmd(arm_reg, `FSPC_CMD_ERASE)
                                   || is_cmd(arm_reg, `FSPC_CMD_WRITE))) begin
            rww_busy_reg <= 1'b1;
        end else if (store_hit && arm_reg == `FSPC_CMD_RWWRE) begin
            rww_busy_reg <= 1'b0;
        end
    end

    // lock bits, programming only clears bits; chip erase restores
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock_reg <= 6'h3f;
        end else if (done && op_reg == fspc_pkg::FSPC_OP_LOCK) begin
            lock_reg <= lock_reg & r1r0[5:0];
        end else if (chip_erase) begin
            lock_reg <= 6'h3f;
        end
    end
    assign lock_bits = lock_reg;

    // page load tracking for eeprom discard
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            load_active_reg <= 1'b0;
        end else if (buf_wr) begin
            load_active_reg <= 1'b1;
        end else if (buf_clear) begin
            load_active_reg <= 1'b0;
        end
    end

    assign buf_wr = store_hit && arm_reg == `FSPC_CMD_LOAD;
    assign buf_clear = (done && op_reg == fspc_pkg::FSPC_OP_WRITE)
                       || (store_hit && arm_reg == `FSPC_CMD_RWWRE)
                       || (load_active_reg && eeprom_write_busy);

    fspc_page_buf #(
        .WORDS(1 << WORD_W),
        .AW(WORD_W)
    ) u_buf (
        .clk(clk),
        .nrst(nrst),
        .clear(buf_clear),
        .wr_en(buf_wr),
        .wr_addr(z_ptr[WORD_W:1]),
        .wr_data(r1r0),
        .rd_addr(flash_word),
        .rd_data(flash_wdata),
        .valid(buf_valid)
    );

    // special reads: lock, fuse, signature
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lpm_data <= 8'hff;
            lpm_special <= 1'b0;
        end else begin
            lpm_special <= load_hit && (arm_reg == `FSPC_CMD_LOCK || arm_reg == `FSPC_CMD_SIG);
            if (load_hit && arm_reg == `FSPC_CMD_LOCK) begin
                unique case (z_ptr)
                    `FSPC_PTR_LOCK: lpm_data <= {2'b11, lock_reg};
                    `FSPC_PTR_FUSE_LO: lpm_data <= fuse_low_byte;
                    `FSPC_PTR_FUSE_EXT: lpm_data <= ext_fuse_byte;
                    `FSPC_PTR_FUSE_HI: lpm_data <= fuse_high_byte;
                    default: lpm_data <= 8'hff;
                endcase
            end else if (load_hit && arm_reg == `FSPC_CMD_SIG) begin
                unique case (z_ptr)
                    16'h0000: lpm_data <= SIG0;
                    16'h0001: lpm_data <= CAL_BYTE;
                    16'h0002: lpm_data <= SIG1;
                    16'h0004: lpm_data <= SIG2;
                    default: lpm_data <= 8'hff;
                endcase
            end
        end
    end

    // interrupt enable bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ie_reg <= 1'b0;
        end else if (csr_wr) begin
            ie_reg <= reg_wdata[`FSPC_B_IE];
        end
    end

    // csr read back
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `FSPC_CSR_ADDR) begin
            reg_rdata <= {ie_reg, rww_busy_reg, arm_reg};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign flash_erase = state_reg == fspc_pkg::FSPC_PROG && op_reg == fspc_pkg::FSPC_OP_ERASE;
    assign flash_write = state_reg == fspc_pkg::FSPC_PROG && op_reg == fspc_pkg::FSPC_OP_WRITE;
    assign rww_read_block = rww_busy_reg;
    assign cpu_stall = (flash_erase || flash_write)
                       && (int'(flash_page) >= STALL_FIRST_PAGE);
    assign spm_irq = ie_reg && !arm_reg[`FSPC_B_ENABLE];

    // checks
    sequence s_lock_armed;
        state_reg == fspc_pkg::FSPC_ARMED && arm_reg == `FSPC_CMD_LOCK;
    endsequence
    sequence s_sig_armed;
        state_reg == fspc_pkg::FSPC_ARMED && is_cmd(arm_reg, `FSPC_CMD_SIG);
    endsequence
    a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        spm_irq == (ie_reg && state_reg == fspc_pkg::FSPC_IDLE)) else $error("irq mismatch");
    a_window_expire: assert property (@(posedge clk) disable iff (!nrst)
        $rose(state_reg == fspc_pkg::FSPC_ARMED) |-> ##[1:4] state_reg != fspc_pkg::FSPC_ARMED)
        else $error("arm window overrun");
    a_ee_block: assert property (@(posedge clk) disable iff (!nrst)
        eeprom_write_busy && state_reg != fspc_pkg::FSPC_PROG
        |=> !flash_erase && !flash_write && !lpm_special) else $error("ee not blocking");
    a_arm_refused: assert property (@(posedge clk) disable iff (!nrst)
        csr_wr && eeprom_write_busy && state_reg == fspc_pkg::FSPC_IDLE
        |=> state_reg == fspc_pkg::FSPC_IDLE) else $error("armed during eeprom write");
    a_rww_hold: assert property (@(posedge clk) disable iff (!nrst)
        flash_erase |=> rww_busy_reg) else $error("rww not busy");
    a_rww_block: assert property (@(posedge clk) disable iff (!nrst)
        flash_erase || flash_write |-> rww_read_block) else $error("section not blocked");
    a_lock_nostall: assert property (@(posedge clk) disable iff (!nrst)
        op_reg == fspc_pkg::FSPC_OP_LOCK |-> !cpu_stall) else $error("stall in lock");
    a_lock_read: assert property (@(posedge clk) disable iff (!nrst)
        s_lock_armed ##0 load_hit ##0 z_ptr == 16'h0001
        |=> lpm_special && lpm_data == {2'b11, $past(lock_reg)}) else $error("lock byte wrong");
    a_sig_read: assert property (@(posedge clk) disable iff (!nrst)
        s_sig_armed ##0 load_hit |=> lpm_special && state_reg == fspc_pkg::FSPC_IDLE)
        else $error("signature read not taken");
    a_lock_only_clears: assert property (@(posedge clk) disable iff (!nrst)
        !chip_erase |=> (lock_reg & ~$past(lock_reg)) == 6'h00)
        else $error("lock bit reverted");
    a_page_latch: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_erase || flash_write) |-> flash_page == $past(page_field))
        else $error("page not latched");
    a_buf_clear: assert property (@(posedge clk) disable iff (!nrst)
        done && op_reg == fspc_pkg::FSPC_OP_WRITE |=> buf_valid == '0)
        else $error("buffer not cleared");
    a_ee_discard: assert property (@(posedge clk) disable iff (!nrst)
        load_active_reg && eeprom_write_busy |=> buf_valid == '0) else $error("loads kept");
    a_prog_time: assert property (@(posedge clk) disable iff (!nrst)
        done |-> prog_len_reg == 32'(PROG_CYCLES - 1)) else $error("program time off");
    a_enable_busy: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == fspc_pkg::FSPC_PROG |-> arm_reg[0]) else $error("enable flag low");
endmodule : fspc_ctrl
`default_nettype wire

// ### rtl/fspc_map.svh
// Overview of operation
// - page erase armed by erase code, then store op within four cycles
// - erase or write to stall section halts cpu for the whole operation
// - page load puts r1r0 word into buffer at pointer bits 5..1
// - buffer cleared after page write, on rww_reenable write, and on reset
// - eeprom write during page loading discards all loaded buffer data
// - page write programs buffer into page_field, armed then store op in four
// - interrupt request held high while spm_enable reads clear and enabled
// - erase or write blocks concurrent section reads, rww_busy held set
// - lock write programs lock bits whose r0 bits 5..0 are zero
// - lock programming keeps whole flash readable, no fetch stall
// - eeprom write busy refuses programming and fuse or lock reads
// - lock read with pointer one within three cycles returns lock byte
// - arming flags clear after read or when the window expires
// - fuse reads: pointer zero low, two extended, three high
// - programmed bits read zero, unprogrammed bits read one
// - sig_read armed load returns signature byte, flags then clear
// - each program operation lasts between 3.7 ms and 4.5 ms
// - signature row: calibration at one, signature at zero, two, four
// - boot lock bits only restored by chip erase or reset
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
`define FSPC_CSR_ADDR 8'h0037
`define FSPC_B_ENABLE 0
`define FSPC_B_PGERS 1
`define FSPC_B_PGWRT 2
`define FSPC_B_LOCK 3
`define FSPC_B_RWWRE 4
`define FSPC_B_SIG 5
`define FSPC_B_RWWBSY 6
`define FSPC_B_IE 7
`define FSPC_CMD_ERASE 6'h03
`define FSPC_CMD_LOAD 6'h01
`define FSPC_CMD_WRITE 6'h05
`define FSPC_CMD_LOCK 6'h09
`define FSPC_CMD_RWWRE 6'h11
`define FSPC_CMD_SIG 6'h21
`define FSPC_ST_WIN 3'h4
`define FSPC_LD_WIN 3'h3
`define FSPC_PROG_NS 4000000
`define FSPC_CLK_NS 5
`define FSPC_PROG_CYC ((`FSPC_PROG_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)
`define FSPC_PTR_LOCK 16'h0001
`define FSPC_PTR_FUSE_LO 16'h0000
`define FSPC_PTR_FUSE_EXT 16'h0002
`define FSPC_PTR_FUSE_HI 16'h0003
`endif

// ### rtl/fspc_pkg.sv
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,
        FSPC_ARMED = 2'b01,
        FSPC_PROG = 2'b10
    } fspc_state_e;
    typedef enum logic [2:0] {
        FSPC_OP_NONE = 3'b000,
        FSPC_OP_ERASE = 3'b001,
        FSPC_OP_WRITE = 3'b010,
        FSPC_OP_LOCK = 3'b011
    } fspc_op_e;
endpackage : fspc_pkg

// ### rtl/fspc_page_buf.sv
`timescale 1ns/10ps
`default_nettype none
// temporary page buffer with registered read data and per-word valid bits
module fspc_page_buf #(
    parameter int WORDS = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data,
    output logic [WORDS-1:0] valid
);
    logic [15:0] mem [WORDS];

    // word storage, no reset needed since valid masks it
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read, erased words read as all ones
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 16'hffff;
        end else begin
            rd_data <= valid[rd_addr] ? mem[rd_addr] : 16'hffff;
        end
    end

    // valid flags, clear wins as it discards the buffer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            valid <= '0;
        end else if (clear) begin
            valid <= '0;
        end else if (wr_en) begin
            valid[wr_addr] <= 1'b1;
        end
    end
endmodule : fspc_page_buf
`default_nettype wire

// ### verif/fspc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// cpu side: issues store and load program ops, holds pointer and data
module fspc_cpu_model (
    input wire logic clk,
    output logic store_program_op,
    output logic load_program_op,
    output logic [15:0] z_ptr,
    output logic [15:0] r1r0
);
    initial begin
        store_program_op = 1'b0;
        load_program_op = 1'b0;
        z_ptr = 16'h0000;
        r1r0 = 16'hffff;
    end
    // one-cycle op; pointer and data stay put until the next op,
    // so a lock write that applies r0 late still sees it
    task automatic op(input logic ld, input logic [15:0] z, input logic [15:0] d);
        @(posedge clk);
        z_ptr <= z;
        r1r0 <= d;
        if (ld) begin
            load_program_op <= 1'b1;
        end else begin
            store_program_op <= 1'b1;
        end
        @(posedge clk);
        load_program_op <= 1'b0;
        store_program_op <= 1'b0;
    endtask : op
endmodule : fspc_cpu_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fspc_map.svh"
// self-checking bench for the self-programming controller
module tb_top;
    localparam logic [7:0] CSR = `FSPC_CSR_ADDR;
    localparam logic [7:0] FUSE_LO = 8'he2;
    localparam logic [7:0] FUSE_HI = 8'hd9;
    localparam logic [7:0] FUSE_EXT = 8'hfd;
    localparam logic [7:0] C_LD = {2'b00, `FSPC_CMD_LOAD};
    localparam logic [7:0] C_ER = {2'b00, `FSPC_CMD_ERASE};
    localparam logic [7:0] C_LK = {2'b00, `FSPC_CMD_LOCK};
    localparam logic [7:0] C_RE = {2'b00, `FSPC_CMD_RWWRE};
    localparam logic [7:0] C_SG = {2'b00, `FSPC_CMD_SIG};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = CSR;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic eeprom_write_busy = 1'b0;
    logic chip_erase = 1'b0;
    logic [4:0] flash_word = 5'h00;
    logic [7:0] reg_rdata, lpm_data, rd;
    logic store_program_op, load_program_op, lpm_special, cpu_stall, rww_read_block;
    logic flash_erase, flash_write, spm_irq;
    logic [15:0] z_ptr, r1r0, flash_wdata;
    logic [6:0] flash_page;
    logic [5:0] lock_bits;
    logic [15:0] sig_z [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
    logic [7:0] sig_v [4] = '{8'h11, 8'h77, 8'h22, 8'h33};
    int miscompares = 0;
    int n_compared = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    fspc_cpu_model i_fspc_cpu_model (.clk(clk), .store_program_op(store_program_op),
        .load_program_op(load_program_op), .z_ptr(z_ptr), .r1r0(r1r0));

    // arbitrary signature and calibration values
    fspc_ctrl #(.PROG_CYCLES(8), .SIG0(8'h11), .SIG1(8'h22), .SIG2(8'h33), .CAL_BYTE(8'h77))
    i_fspc_ctrl (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .store_program_op(store_program_op), .load_program_op(load_program_op),
        .z_ptr(z_ptr), .r1r0(r1r0), .eeprom_write_busy(eeprom_write_busy),
        .fuse_low_byte(FUSE_LO), .fuse_high_byte(FUSE_HI), .ext_fuse_byte(FUSE_EXT),
        .chip_erase(chip_erase), .lpm_special(lpm_special), .lpm_data(lpm_data),
        .cpu_stall(cpu_stall), .rww_read_block(rww_read_block), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page), .flash_word(flash_word),
        .flash_wdata(flash_wdata), .lock_bits(lock_bits), .spm_irq(spm_irq));

    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // register write: one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // register read: data stands in the cycle after the strobe
    task automatic rd8(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd8

    // poll until the enable flag drops, bounded
    task automatic wait_idle();
        int n;
        n = 0;
        rd8(CSR, rd);
        while (rd[0] !== 1'b0) begin
            n++;
            if (n > 40) begin
                chk("enable flag timeout", 16'h0001, 16'h0000);
                report_and_stop();
            end
            rd8(CSR, rd);
        end
    endtask : wait_idle

    // arm, then store op in the window
    task automatic spm(input logic [7:0] code, input logic [15:0] z, input logic [15:0] d);
        wr(CSR, code);
        i_fspc_cpu_model.op(1'b0, z, d);
        #1;
    endtask : spm

    // arm, then load op in the window; check the special read
    task automatic lpm_chk(input logic [7:0] code, input logic [15:0] z, input logic [7:0] exp,
            input logic [7:0] mask, input logic hit);
        wr(CSR, code);
        i_fspc_cpu_model.op(1'b1, z, 16'hffff);
        #1;
        chk("lpm_special", lpm_special, hit);
        if (hit) begin
            chk("lpm_data", lpm_data & mask, exp);
        end
    endtask : lpm_chk

    // read one buffer word back
    task automatic buf_chk(input logic [4:0] w, input logic [15:0] exp);
        @(posedge clk);
        flash_word <= w;
        @(posedge clk);
        #1 chk("flash_wdata", flash_wdata, exp);
    endtask : buf_chk

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd8(CSR, rd);
        chk("csr after reset", rd, 16'h0000);
        chk("lock_bits after reset", lock_bits, 16'h003f);
        buf_chk(5'd0, 16'hffff);
        rd8(8'h38, rd);
        chk("unmapped read", rd, 16'h0000);
        // fuse, lock and signature reads
        lpm_chk(C_LK, `FSPC_PTR_LOCK, 8'h3f, 8'h3f, 1'b1);
        rd8(CSR, rd);
        chk("flags after read", rd[5:0], 16'h0000);
        lpm_chk(C_LK, `FSPC_PTR_FUSE_LO, FUSE_LO, 8'hff, 1'b1);
        lpm_chk(C_LK, `FSPC_PTR_FUSE_EXT, FUSE_EXT, 8'hff, 1'b1);
        lpm_chk(C_LK, `FSPC_PTR_FUSE_HI, FUSE_HI, 8'hff, 1'b1);
        foreach (sig_z[i]) lpm_chk(C_SG, sig_z[i], sig_v[i], 8'hff, 1'b1);
        // late load after the window is plain flash read
        wr(CSR, C_LK);
        repeat (4) @(posedge clk);
        i_fspc_cpu_model.op(1'b1, 16'h0001, 16'hffff);
        #1 chk("late lpm_special", lpm_special, 16'h0000);
        // late store does not erase
        wr(CSR, C_ER);
        repeat (4) @(posedge clk);
        i_fspc_cpu_model.op(1'b0, 16'h0140, 16'h0000);
        #1 chk("late erase", flash_erase, 16'h0000);
        rd8(CSR, rd);
        chk("flag after late store", rd[0], 16'h0000);
        // fill buffer at both ends, then write page 5 with irq enabled
        spm(C_LD, 16'h0000, 16'h1234);
        wait_idle();
        spm(C_LD, 16'h003e, 16'hbeef);
        wait_idle();
        buf_chk(5'd0, 16'h1234);
        buf_chk(5'd31, 16'hbeef);
        buf_chk(5'd1, 16'hffff);
        spm({2'b10, `FSPC_CMD_WRITE}, 16'h0140, 16'h0000);
        chk("flash_write", flash_write, 16'h0001);
        chk("write page", flash_page, 16'h0005);
        chk("stall on low page", cpu_stall, 16'h0000);
        chk("block during write", rww_read_block, 16'h0001);
        chk("irq while busy", spm_irq, 16'h0000);
        rd8(CSR, rd);
        chk("enable while busy", rd[0], 16'h0001);
        wait_idle();
        chk("write ended", flash_write, 16'h0000);
        chk("irq when done", spm_irq, 16'h0001);
        chk("busy bit held", rd[6], 16'h0001);
        chk("block held", rww_read_block, 16'h0001);
        buf_chk(5'd0, 16'hffff);
        spm(C_LD, 16'h0004, 16'h5555);
        wait_idle();
        buf_chk(5'd2, 16'h5555);
        spm(C_RE, 16'h0000, 16'h0000);
        wait_idle();
        chk("busy bit cleared", rd[6], 16'h0000);
        chk("block released", rww_read_block, 16'h0000);
        chk("irq disabled", spm_irq, 16'h0000);
        buf_chk(5'd2, 16'hffff);
        // erase of a high page stalls the cpu; word bits ignored
        spm(C_ER, 16'h1c7e, 16'h0000);
        chk("flash_erase", flash_erase, 16'h0001);
        chk("erase page", flash_page, 16'h0071);
        chk("stall on high page", cpu_stall, 16'h0001);
        wait_idle();
        chk("stall released", cpu_stall, 16'h0000);
        spm(C_RE, 16'h0000, 16'h0000);
        wait_idle();
        // lock write keeps flash readable; bits restored only by chip erase or reset
        spm(C_LK, 16'h0001, 16'h00fa);
        chk("no stall in lock", cpu_stall, 16'h0000);
        chk("no block in lock", rww_read_block, 16'h0000);
        wait_idle();
        chk("lock_bits set", lock_bits, 16'h003a);
        lpm_chk(C_LK, `FSPC_PTR_LOCK, 8'h3a, 8'h3f, 1'b1);
        spm(C_LK, 16'h0001, 16'h00ff);
        wait_idle();
        chk("lock_bits kept", lock_bits, 16'h003a);
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        #1 chk("lock_bits erased", lock_bits, 16'h003f);
        // eeprom write discards loads and refuses programming and reads
        spm(C_LD, 16'h0006, 16'h0f0f);
        wait_idle();
        @(posedge clk);
        eeprom_write_busy <= 1'b1;
        buf_chk(5'd3, 16'hffff);
        spm(C_ER, 16'h0140, 16'h0000);
        chk("erase refused", flash_erase, 16'h0000);
        rd8(CSR, rd);
        chk("arm refused", rd[0], 16'h0000);
        lpm_chk(C_LK, `FSPC_PTR_FUSE_LO, FUSE_LO, 8'hff, 1'b0);
        @(posedge clk);
        eeprom_write_busy <= 1'b0;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
